// >>> verilog/ifm_top.sv
// input function mapper: terminal, serial and fieldbus sources to drive functions
//
// Functional notes
// - eight inputs, each routed to the function its own selection names
// - codes 03, 04, 07, 06, 14 enable the reference sources
// - codes 09, 10, 11 drive potentiometer up, down, reload last value
// - code 24 freezes speed integral, code 26 selects speed regulator bank two
// - code 18 enables time-decoded, code 19 pulse-based frequency reference
// - code 12 inverts speed reference, code 22 enables linear ramps
// - code 01 torque control, 05 jog, 16 second parameter bank
// - code 17 axis space loop, 23 thermal switch, 25 position loop offset
// - codes 27 to 30 drive the process PID controls
// - reset assigns run to input 4, alarm clear to 1, permit to 2
// - unassigned functions take default: permit active, others inactive
// - a selection already held by another input is rejected, old value kept
// - value -1 disconnects an input and may be held by many inputs
// - inputs are filtered 2.2 ms; filtered high activates the function
// - polarity mask bit n makes input n active low
// - run needs terminal, serial and fieldbus; fieldbus defaults asserted
// - every other function is the OR of its three sources
// - the frequency enable parameter also enables pulse frequency reference
module ifm_top #(
    parameter int FILT_CYCLES = ifm_pkg::FILT_CYCLES
) (
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    // terminal pins
    input wire logic [ifm_pkg::NUM_INPUTS-1:0] i_term_in,
    // selection write and read back
    input wire logic i_sel_wr,
    input wire logic [2:0] i_sel_idx,
    input wire logic [ifm_pkg::CODE_W-1:0] i_sel_code,
    input wire logic [2:0] i_sel_rd_idx,
    output logic [ifm_pkg::CODE_W-1:0] o_sel_rd_code,
    output logic o_sel_accepted,
    output logic o_sel_rejected,
    // configuration
    input wire logic [ifm_pkg::NUM_INPUTS-1:0] i_input_polarity_mask,
    input wire logic i_freq_ref_enable_param,
    // serial and fieldbus command words
    input wire logic i_serial_wr,
    input wire logic [ifm_pkg::NUM_FUNCS-1:0] i_serial_func,
    input wire logic i_fieldbus_wr,
    input wire logic [ifm_pkg::NUM_FUNCS-1:0] i_fieldbus_func,
    // status
    output logic [ifm_pkg::NUM_INPUTS-1:0] o_filtered_inputs,
    output logic [ifm_pkg::NUM_FUNCS-1:0] o_terminal_functions,
    output logic [ifm_pkg::NUM_FUNCS-1:0] o_assigned_functions,
    output logic [ifm_pkg::NUM_FUNCS-1:0] o_functions,
    // named function outputs
    output logic o_run_function,
    output logic o_torque_mode_function,
    output logic o_external_permit,
    output logic o_speed_analog_ref_enable,
    output logic o_torque_analog_ref_enable,
    output logic o_jog_enable,
    output logic o_pot_speed_ref_enable,
    output logic o_torque_limit_analog_enable,
    output logic o_alarm_clear_function,
    output logic o_pot_count_up,
    output logic o_pot_count_down,
    output logic o_pot_reload_last,
    output logic o_speed_ref_invert,
    output logic o_fieldbus_ref_enable,
    output logic o_second_param_bank_enable,
    output logic o_axis_space_loop_enable,
    output logic o_time_decoded_freq_ref_enable,
    output logic o_pulse_freq_ref_enable,
    output logic o_linear_ramp_enable,
    output logic o_motor_thermal_switch,
    output logic o_speed_integral_freeze,
    output logic o_position_loop_offset_enable,
    output logic o_speed_reg_bank_two_enable,
    output logic o_pid_digital_setpoint_enable,
    output logic o_pid_auto_enable,
    output logic o_pid_output_ref_enable,
    output logic o_pid_manual_setpoint_enable
);

    typedef struct packed {
        logic [ifm_pkg::NUM_FUNCS-1:0] serial;
        logic [ifm_pkg::NUM_FUNCS-1:0] fieldbus;
        logic [ifm_pkg::NUM_FUNCS-1:0] term;
        logic [ifm_pkg::NUM_FUNCS-1:0] assigned;
        logic [ifm_pkg::NUM_FUNCS-1:0] func;
    } ifm_top_state_t;

    ifm_top_state_t q, d;

    logic [ifm_pkg::NUM_INPUTS-1:0] filt_level;
    logic [ifm_pkg::NUM_INPUTS-1:0][ifm_pkg::CODE_W-1:0] sel_codes;
    logic [ifm_pkg::NUM_INPUTS-1:0] active_in;
    logic [ifm_pkg::NUM_FUNCS-1:0] term_lvl;
    logic [ifm_pkg::NUM_FUNCS-1:0] hit;
    logic [ifm_pkg::NUM_FUNCS-1:0] merged;

    // the filter delays every edge by the two synchroniser stages plus the window, glitches shorter vanish
    ifm_filter #(
        .N(ifm_pkg::NUM_INPUTS),
        .CNT_W(ifm_pkg::FILT_CNT_W),
        .CYCLES(FILT_CYCLES)
    ) u_filter (
        .i_clk_sys(i_clk_sys),
        .i_resetn(i_resetn),
        .i_pin(i_term_in),
        .o_level(filt_level)
    );

    ifm_select u_select (
        .i_clk_sys(i_clk_sys),
        .i_resetn(i_resetn),
        .i_wr(i_sel_wr),
        .i_wr_idx(i_sel_idx),
        .i_wr_code(i_sel_code),
        .i_rd_idx(i_sel_rd_idx),
        .o_rd_code(o_sel_rd_code),
        .o_codes(sel_codes),
        .o_ack(o_sel_accepted),
        .o_nak(o_sel_rejected)
    );

    // polarity applied after the filter so the window is symmetric
    assign active_in = filt_level ^ i_input_polarity_mask;

    always_comb begin
        d = q;
        term_lvl = ifm_pkg::FUNC_DEFAULT;
        hit = '0;
        merged = '0;

        // terminal side: one input at most can carry a given function
        for (int f = 0; f < ifm_pkg::NUM_FUNCS; f++) begin
            for (int i = 0; i < ifm_pkg::NUM_INPUTS; i++) begin
                if (sel_codes[i] == ifm_pkg::CODE_W'(f)) begin
                    hit[f] = 1'b1;
                end
            end
        end
        for (int f = 0; f < ifm_pkg::NUM_FUNCS; f++) begin
            if (hit[f]) begin
                term_lvl[f] = 1'b0;
            end
        end
        for (int i = 0; i < ifm_pkg::NUM_INPUTS; i++) begin
            // disconnected inputs never reach a function
            if (sel_codes[i] != ifm_pkg::CODE_NONE) begin
                term_lvl[sel_codes[i][4:0]] = active_in[i];
            end
        end

        // command words from the other two sources
        if (i_serial_wr) begin
            d.serial = i_serial_func;
        end
        if (i_fieldbus_wr) begin
            d.fieldbus = i_fieldbus_func;
        end

        // others are the parallel of all three sources
        merged = q.term | q.serial | q.fieldbus;
        // run must be confirmed by every source
        merged[ifm_pkg::F_RUN[4:0]] = q.term[ifm_pkg::F_RUN[4:0]] &
            q.serial[ifm_pkg::F_RUN[4:0]] & q.fieldbus[ifm_pkg::F_RUN[4:0]];
        // parameter route to the pulse reference bypasses the inputs
        merged[ifm_pkg::F_PULSE_FREQ_REF[4:0]] =
            merged[ifm_pkg::F_PULSE_FREQ_REF[4:0]] | i_freq_ref_enable_param;

        d.term = term_lvl;
        d.assigned = hit;
        d.func = merged;
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            q <= '{
                serial: ifm_pkg::SERIAL_RESET,
                fieldbus: ifm_pkg::FIELDBUS_RESET,
                term: ifm_pkg::FUNC_DEFAULT,
                assigned: '0,
                func: '0
            };
        end else begin
            q <= d;
        end
    end

    assign o_filtered_inputs = filt_level;
    assign o_terminal_functions = q.term;
    assign o_assigned_functions = q.assigned;
    assign o_functions = q.func;

    // drive control and permits
    assign o_run_function = q.func[ifm_pkg::F_RUN[4:0]];
    assign o_torque_mode_function = q.func[ifm_pkg::F_TORQUE_MODE[4:0]];
    assign o_external_permit = q.func[ifm_pkg::F_EXT_PERMIT[4:0]];
    assign o_alarm_clear_function = q.func[ifm_pkg::F_ALARM_CLEAR[4:0]];
    assign o_jog_enable = q.func[ifm_pkg::F_JOG[4:0]];
    assign o_second_param_bank_enable = q.func[ifm_pkg::F_PARAM_BANK2[4:0]];

    // reference sources
    assign o_speed_analog_ref_enable = q.func[ifm_pkg::F_SPD_AN_REF[4:0]];
    assign o_torque_analog_ref_enable = q.func[ifm_pkg::F_TRQ_AN_REF[4:0]];
    assign o_torque_limit_analog_enable = q.func[ifm_pkg::F_TRQ_LIM_AN[4:0]];
    assign o_pot_speed_ref_enable = q.func[ifm_pkg::F_POT_SPD_REF[4:0]];
    assign o_fieldbus_ref_enable = q.func[ifm_pkg::F_FIELDBUS_REF[4:0]];

    // digital potentiometer
    assign o_pot_count_up = q.func[ifm_pkg::F_POT_UP[4:0]];
    assign o_pot_count_down = q.func[ifm_pkg::F_POT_DOWN[4:0]];
    assign o_pot_reload_last = q.func[ifm_pkg::F_POT_RELOAD[4:0]];

    // speed regulator
    assign o_speed_integral_freeze = q.func[ifm_pkg::F_INTEGRAL_FREEZE[4:0]];
    assign o_speed_reg_bank_two_enable = q.func[ifm_pkg::F_SPD_REG_BANK2[4:0]];

    // frequency references
    assign o_time_decoded_freq_ref_enable = q.func[ifm_pkg::F_TIME_FREQ_REF[4:0]];
    assign o_pulse_freq_ref_enable = q.func[ifm_pkg::F_PULSE_FREQ_REF[4:0]];

    // reference shaping
    assign o_speed_ref_invert = q.func[ifm_pkg::F_SPD_INVERT[4:0]];
    assign o_linear_ramp_enable = q.func[ifm_pkg::F_LINEAR_RAMP[4:0]];

    // axis, protection, position loop
    assign o_axis_space_loop_enable = q.func[ifm_pkg::F_AXIS_LOOP[4:0]];
    assign o_motor_thermal_switch = q.func[ifm_pkg::F_THERMAL_SW[4:0]];
    assign o_position_loop_offset_enable = q.func[ifm_pkg::F_POS_LOOP_OFS[4:0]];

    // process PID controls
    assign o_pid_digital_setpoint_enable = q.func[ifm_pkg::F_PID_DIG_SETPT[4:0]];
    assign o_pid_auto_enable = q.func[ifm_pkg::F_PID_AUTO[4:0]];
    assign o_pid_output_ref_enable = q.func[ifm_pkg::F_PID_OUT_REF[4:0]];
    assign o_pid_manual_setpoint_enable = q.func[ifm_pkg::F_PID_MAN_SETPT[4:0]];

endmodule // ifm_top

// >>> verilog/ifm_pkg.sv
// shared constants for the input function mapper
package ifm_pkg;

    localparam int NUM_INPUTS = 8;
    localparam int NUM_FUNCS = 32;
    localparam int CODE_W = 6;

    // selection value that disconnects an input
    localparam logic [CODE_W-1:0] CODE_NONE = 6'h3F;

    // function codes
    localparam logic [CODE_W-1:0] F_RUN = 6'h00;
    localparam logic [CODE_W-1:0] F_TORQUE_MODE = 6'h01;
    localparam logic [CODE_W-1:0] F_EXT_PERMIT = 6'h02;
    localparam logic [CODE_W-1:0] F_SPD_AN_REF = 6'h03;
    localparam logic [CODE_W-1:0] F_TRQ_AN_REF = 6'h04;
    localparam logic [CODE_W-1:0] F_JOG = 6'h05;
    localparam logic [CODE_W-1:0] F_POT_SPD_REF = 6'h06;
    localparam logic [CODE_W-1:0] F_TRQ_LIM_AN = 6'h07;
    localparam logic [CODE_W-1:0] F_ALARM_CLEAR = 6'h08;
    localparam logic [CODE_W-1:0] F_POT_UP = 6'h09;
    localparam logic [CODE_W-1:0] F_POT_DOWN = 6'h0A;
    localparam logic [CODE_W-1:0] F_POT_RELOAD = 6'h0B;
    localparam logic [CODE_W-1:0] F_SPD_INVERT = 6'h0C;
    localparam logic [CODE_W-1:0] F_FIELDBUS_REF = 6'h0E;
    localparam logic [CODE_W-1:0] F_PARAM_BANK2 = 6'h10;
    localparam logic [CODE_W-1:0] F_AXIS_LOOP = 6'h11;
    localparam logic [CODE_W-1:0] F_TIME_FREQ_REF = 6'h12;
    localparam logic [CODE_W-1:0] F_PULSE_FREQ_REF = 6'h13;
    localparam logic [CODE_W-1:0] F_LINEAR_RAMP = 6'h16;
    localparam logic [CODE_W-1:0] F_THERMAL_SW = 6'h17;
    localparam logic [CODE_W-1:0] F_INTEGRAL_FREEZE = 6'h18;
    localparam logic [CODE_W-1:0] F_POS_LOOP_OFS = 6'h19;
    localparam logic [CODE_W-1:0] F_SPD_REG_BANK2 = 6'h1A;
    localparam logic [CODE_W-1:0] F_PID_DIG_SETPT = 6'h1B;
    localparam logic [CODE_W-1:0] F_PID_AUTO = 6'h1C;
    localparam logic [CODE_W-1:0] F_PID_OUT_REF = 6'h1D;
    localparam logic [CODE_W-1:0] F_PID_MAN_SETPT = 6'h1E;

    // selection after reset, index 0 is terminal input 1
    localparam logic [NUM_INPUTS-1:0][CODE_W-1:0] SEL_RESET = {
        6'h16, 6'h05, 6'h0C, 6'h04, 6'h00, 6'h03, 6'h02, 6'h08};

    // level of each unassigned function: only external permit defaults high
    localparam logic [NUM_FUNCS-1:0] FUNC_DEFAULT = 32'h0000_0004;
    localparam logic [NUM_FUNCS-1:0] SERIAL_RESET = 32'h0000_0000;
    localparam logic [NUM_FUNCS-1:0] FIELDBUS_RESET = 32'h0000_0001;

    // input filter time
    localparam real FILT_TIME_MS = 2.2;
    localparam real CLK_PERIOD_NS = 100.0;
    localparam int FILT_CYCLES = int'($ceil(FILT_TIME_MS * 1.0e6 / CLK_PERIOD_NS));
    localparam int FILT_CNT_W = 16;

    // a legal selection is a function code or the disconnect value
    function automatic logic code_legal(input logic [CODE_W-1:0] code);
        code_legal = (code == CODE_NONE) || (code < CODE_W'(NUM_FUNCS));
    endfunction

endpackage

// >>> verilog/ifm_filter.sv
// synchroniser and stability filter for the terminal inputs
module ifm_filter #(
    parameter int N = 8,
    parameter int CNT_W = 16,
    parameter int CYCLES = 22000
) (
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic [N-1:0] i_pin,
    output logic [N-1:0] o_level
);

    typedef struct packed {
        logic [N-1:0] meta;
        logic [N-1:0] sync;
        logic [N-1:0] level;
        logic [N-1:0][CNT_W-1:0] cnt;
    } ifm_filt_state_t;

    ifm_filt_state_t q, d;

    always_comb begin
        d = q;
        d.meta = i_pin;
        d.sync = q.meta;
        for (int i = 0; i < N; i++) begin
            // a level must hold for the whole window before it is taken
            if (q.sync[i] == q.level[i]) begin
                d.cnt[i] = '0;
            end else if (q.cnt[i] >= CNT_W'(CYCLES - 1)) begin
                d.cnt[i] = '0;
                d.level[i] = q.sync[i];
            end else begin
                d.cnt[i] = q.cnt[i] + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign o_level = q.level;

endmodule // ifm_filter

// >>> verilog/ifm_select.sv
// per-input function selection table with duplicate rejection
module ifm_select (
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic i_wr,
    input wire logic [2:0] i_wr_idx,
    input wire logic [ifm_pkg::CODE_W-1:0] i_wr_code,
    input wire logic [2:0] i_rd_idx,
    output logic [ifm_pkg::CODE_W-1:0] o_rd_code,
    output logic [ifm_pkg::NUM_INPUTS-1:0][ifm_pkg::CODE_W-1:0] o_codes,
    output logic o_ack,
    output logic o_nak
);

    typedef struct packed {
        logic [ifm_pkg::NUM_INPUTS-1:0][ifm_pkg::CODE_W-1:0] code;
        logic ack;
        logic nak;
    } ifm_sel_state_t;

    ifm_sel_state_t q, d;
    logic clash;

    always_comb begin
        d = q;
        d.ack = 1'b0;
        d.nak = 1'b0;
        clash = 1'b0;
        // disconnect value may be shared by any number of inputs
        for (int j = 0; j < ifm_pkg::NUM_INPUTS; j++) begin
            if (3'(j) != i_wr_idx && q.code[j] == i_wr_code &&
                    i_wr_code != ifm_pkg::CODE_NONE) begin
                clash = 1'b1;
            end
        end
        if (i_wr) begin
            if (clash || !ifm_pkg::code_legal(i_wr_code)) begin
                d.nak = 1'b1;
            end else begin
                d.code[i_wr_idx] = i_wr_code;
                d.ack = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            q <= '{code: ifm_pkg::SEL_RESET, ack: 1'b0, nak: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign o_codes = q.code;
    assign o_rd_code = q.code[i_rd_idx];
    assign o_ack = q.ack;
    assign o_nak = q.nak;

endmodule // ifm_select

// >>> dv/ifm_top_props.sv
// assertion checker for the input function mapper ports
module ifm_top_props #(
    parameter int FILT_CYCLES = 4
) (
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic [ifm_pkg::NUM_INPUTS-1:0] i_term_in,
    input wire logic i_sel_wr,
    input wire logic [ifm_pkg::CODE_W-1:0] i_sel_code,
    input wire logic i_freq_ref_enable_param,
    input wire logic o_sel_accepted,
    input wire logic o_sel_rejected,
    input wire logic [ifm_pkg::NUM_INPUTS-1:0] o_filtered_inputs,
    input wire logic [ifm_pkg::NUM_FUNCS-1:0] o_terminal_functions,
    input wire logic [ifm_pkg::NUM_FUNCS-1:0] o_assigned_functions,
    input wire logic [ifm_pkg::NUM_FUNCS-1:0] o_functions,
    input wire logic o_run_function,
    input wire logic o_jog_enable,
    input wire logic o_pulse_freq_ref_enable
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_resetn);

    AST_SEL_ANSWER: assert property (i_sel_wr |=> o_sel_accepted != o_sel_rejected)
        else $error("selection write got no single answer");
    AST_SEL_QUIET: assert property (!i_sel_wr |=> !o_sel_accepted && !o_sel_rejected)
        else $error("selection answer without a write");
    AST_SEL_ILLEGAL: assert property ((i_sel_wr && i_sel_code inside {[6'h20:6'h3E]})
        |=> o_sel_rejected)
        else $error("illegal code not refused");
    AST_RUN_AND: assert property ($past(i_resetn) && o_run_function
        |-> $past(o_terminal_functions[0]))
        else $error("run active without terminal source");
    AST_OR_MERGE: assert property ($past(i_resetn) |-> (32'hFFFF_FFFE
        & $past(o_terminal_functions) & ~o_functions) == 32'h0000_0000)
        else $error("terminal function lost in merge");
    AST_PULSE_PARAM: assert property (i_freq_ref_enable_param [*2]
        |=> o_pulse_freq_ref_enable)
        else $error("frequency parameter did not enable pulse reference");
    AST_SLICES: assert property (o_run_function == o_functions[0]
        && o_jog_enable == o_functions[5] && o_pulse_freq_ref_enable == o_functions[19])
        else $error("named output differs from function vector");
    AST_DEFAULTS: assert property ((~o_assigned_functions & o_terminal_functions)
        == (o_assigned_functions[2] ? 32'h0000_0000 : 32'h0000_0004))
        else $error("unassigned function not at default level");
    // depth 3 stays inside the settling window for any filter of two or more cycles
    AST_FILTER: assert property ($past(i_resetn) && $changed(o_filtered_inputs)
        |-> ((o_filtered_inputs ^ $past(o_filtered_inputs))
        & (o_filtered_inputs ^ $past(i_term_in, 3))) == 8'h00)
        else $error("filtered level flipped without a stable pin");
endmodule // ifm_top_props

bind ifm_top ifm_top_props #(.FILT_CYCLES(FILT_CYCLES)) i_ifm_top_props (
    .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_term_in(i_term_in),
    .i_sel_wr(i_sel_wr), .i_sel_code(i_sel_code),
    .i_freq_ref_enable_param(i_freq_ref_enable_param),
    .o_sel_accepted(o_sel_accepted), .o_sel_rejected(o_sel_rejected),
    .o_filtered_inputs(o_filtered_inputs), .o_terminal_functions(o_terminal_functions),
    .o_assigned_functions(o_assigned_functions), .o_functions(o_functions),
    .o_run_function(o_run_function), .o_jog_enable(o_jog_enable),
    .o_pulse_freq_ref_enable(o_pulse_freq_ref_enable));

// >>> dv/ifm_field_model.sv
// field side model: terminal pins plus serial and fieldbus command words
module ifm_field_model (
    input wire logic i_clk_sys,
    input wire logic [7:0] i_pins,
    input wire logic i_load,
    input wire logic [31:0] i_ser_word,
    input wire logic [31:0] i_fb_word,
    output logic [7:0] o_term_in,
    output logic o_serial_wr,
    output logic [31:0] o_serial_func,
    output logic o_fieldbus_wr,
    output logic [31:0] o_fieldbus_func
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        o_term_in = 8'h00;
        o_serial_wr = 1'b0;
        o_fieldbus_wr = 1'b0;
        o_serial_func = 32'hA5A5_A5A5;
        o_fieldbus_func = 32'h5A5A_5A5A;
    end
    always @(negedge i_clk_sys) begin
        #1;
        o_term_in <= i_pins;
        o_serial_wr <= i_load;
        o_fieldbus_wr <= i_load;
        // words only mean something with the strobe, so show junk outside it
        o_serial_func <= i_load ? i_ser_word : ~i_ser_word;
        o_fieldbus_func <= i_load ? i_fb_word : ~i_fb_word;
    end
endmodule // ifm_field_model

// >>> dv/test_input_function_mapper.sv
// self-checking bench for the input function mapper
module test_input_function_mapper;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int FILT = 4;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic sel_wr = 1'b0;
    logic [2:0] sel_idx = 3'h0;
    logic [5:0] sel_code = 6'h00;
    logic [2:0] rd_idx = 3'h0;
    logic [7:0] mask = 8'h00;
    logic param = 1'b0;
    logic [7:0] pins = 8'h00;
    logic load = 1'b0;
    logic [31:0] ser_w = 32'h0000_0000;
    logic [31:0] fb_w = 32'h0000_0001;
    logic [7:0] term_in;
    logic s_wr;
    logic f_wr;
    logic [31:0] s_func;
    logic [31:0] f_func;
    logic [5:0] rd_code;
    logic acc;
    logic rej;
    logic [7:0] filt;
    logic [31:0] funcs;
    wire [31:0] named;
    int sel_m[8];
    int fail_count = 0;
    int check_count = 0;

    ifm_field_model i_ifm_field_model (.i_clk_sys(clk_sys), .i_pins(pins), .i_load(load),
        .i_ser_word(ser_w), .i_fb_word(fb_w), .o_term_in(term_in), .o_serial_wr(s_wr),
        .o_serial_func(s_func), .o_fieldbus_wr(f_wr), .o_fieldbus_func(f_func));
    ifm_top #(.FILT_CYCLES(FILT)) i_ifm_top (.i_clk_sys(clk_sys), .i_resetn(resetn),
        .i_term_in(term_in), .i_sel_wr(sel_wr), .i_sel_idx(sel_idx), .i_sel_code(sel_code),
        .i_sel_rd_idx(rd_idx), .o_sel_rd_code(rd_code), .o_sel_accepted(acc),
        .o_sel_rejected(rej), .i_input_polarity_mask(mask), .i_freq_ref_enable_param(param),
        .i_serial_wr(s_wr), .i_serial_func(s_func), .i_fieldbus_wr(f_wr),
        .i_fieldbus_func(f_func), .o_filtered_inputs(filt), .o_terminal_functions(),
        .o_assigned_functions(), .o_functions(funcs), .o_run_function(named[0]),
        .o_torque_mode_function(named[1]), .o_external_permit(named[2]),
        .o_speed_analog_ref_enable(named[3]), .o_torque_analog_ref_enable(named[4]),
        .o_jog_enable(named[5]), .o_pot_speed_ref_enable(named[6]),
        .o_torque_limit_analog_enable(named[7]), .o_alarm_clear_function(named[8]),
        .o_pot_count_up(named[9]), .o_pot_count_down(named[10]),
        .o_pot_reload_last(named[11]), .o_speed_ref_invert(named[12]),
        .o_fieldbus_ref_enable(named[14]), .o_second_param_bank_enable(named[16]),
        .o_axis_space_loop_enable(named[17]), .o_time_decoded_freq_ref_enable(named[18]),
        .o_pulse_freq_ref_enable(named[19]), .o_linear_ramp_enable(named[22]),
        .o_motor_thermal_switch(named[23]), .o_speed_integral_freeze(named[24]),
        .o_position_loop_offset_enable(named[25]), .o_speed_reg_bank_two_enable(named[26]),
        .o_pid_digital_setpoint_enable(named[27]), .o_pid_auto_enable(named[28]),
        .o_pid_output_ref_enable(named[29]), .o_pid_manual_setpoint_enable(named[30]));

    initial begin
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk_vec(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_ack(input logic a, input logic r, input logic ok);
        check_count++;
        if ({a, r} !== {ok, !ok}) begin
            fail_count++;
            $display("unexpected answer at %0t: got %h expected %h", $time, {a, r}, {ok, !ok});
        end
    endtask

    // the bench's own view of the merged function vector
    function automatic logic [31:0] exp_funcs();
        logic [31:0] t;
        t = 32'h0000_0004;
        for (int i = 0; i < 8; i++) begin
            if (sel_m[i] < 32) t[sel_m[i]] = pins[i] ^ mask[i];
        end
        exp_funcs = t | ser_w | fb_w;
        exp_funcs[0] = t[0] & ser_w[0] & fb_w[0];
        exp_funcs[19] = exp_funcs[19] | param;
    endfunction

    task automatic settle();
        repeat (FILT + 8) @(negedge clk_sys);
        chk_vec(funcs, exp_funcs());
        // codes 13, 15, 20, 21 and 31 have no named output
        chk_vec(named & 32'h7FCF_5FFF, exp_funcs() & 32'h7FCF_5FFF);
        chk_vec({24'h0, filt}, {24'h0, pins});
    endtask

    task automatic sel_write(input int idx, input logic [5:0] code);
        logic ok;
        ok = (code == 6'h3F) || (code < 6'h20);
        for (int i = 0; i < 8; i++) begin
            if (i != idx && code != 6'h3F && sel_m[i] == int'(code)) ok = 1'b0;
        end
        sel_wr = 1'b1;
        sel_idx = idx[2:0];
        sel_code = code;
        @(negedge clk_sys);
        chk_ack(acc, rej, ok);
        if (ok) sel_m[idx] = int'(code);
    endtask

    task automatic read_all();
        for (int i = 0; i < 8; i++) begin
            rd_idx = i[2:0];
            @(negedge clk_sys);
            chk_vec({26'h0, rd_code}, 32'(sel_m[i]));
        end
    endtask

    task automatic load_words(input logic [31:0] s, input logic [31:0] f);
        ser_w = s;
        fb_w = f;
        load = 1'b1;
        @(negedge clk_sys);
        load = 1'b0;
    endtask

    task automatic reset_dut();
        resetn = 1'b0;
        repeat (6) @(negedge clk_sys);
        resetn = 1'b1;
        sel_m = '{8, 2, 3, 0, 4, 12, 5, 22};
        ser_w = 32'h0000_0000;
        fb_w = 32'h0000_0001;
    endtask

    initial begin
        repeat (100000) @(posedge clk_sys);
        fail_count++;
        tally_and_finish();
    end

    initial begin
        void'($urandom(32'h193E7AC7));
        reset_dut();
        settle();
        read_all();
        // every input parked on -1, written back to back
        for (int i = 0; i < 8; i++) sel_write(i, 6'h3F);
        sel_write(0, 6'h05);
        sel_write(1, 6'h05);
        sel_write(2, 6'h28);
        sel_write(3, 6'h3E);
        sel_write(0, 6'h3F);
        sel_wr = 1'b0;
        read_all();
        load_words(32'h0000_0001, 32'h0000_0001);
        // walk every code through input 8, active then idle
        for (int f = 0; f < 32; f++) begin
            sel_write(7, 6'(f));
            sel_wr = 1'b0;
            pins = 8'($urandom);
            mask = 8'($urandom);
            pins[7] = ~mask[7];
            settle();
            pins[7] = mask[7];
            settle();
        end
        repeat (40) begin
            sel_write(int'($urandom % 8), 6'($urandom));
            sel_wr = 1'b0;
            pins = 8'($urandom);
            mask = 8'($urandom);
            param = 1'($urandom);
            if ($urandom % 3 == 0) load_words($urandom, $urandom);
            settle();
        end
        // a glitch shorter than the filter must not pass
        pins[0] = ~pins[0];
        repeat (2) @(negedge clk_sys);
        pins[0] = ~pins[0];
        // look while an unfiltered glitch would still be showing
        repeat (2) begin
            @(negedge clk_sys);
            chk_vec({24'h0, filt}, {24'h0, pins});
        end
        settle();
        reset_dut();
        settle();
        read_all();
        tally_and_finish();
    end
endmodule // test_input_function_mapper
